// File: rtl/scp_top.sv
// start code search, transport packet parse, program map learning, payload routing
// assumes serial bits msb first from logic on i_core_clk; one bit per cycle at most
`timescale 1ns/1ps
`include "scp_defs.svh"
`default_nettype none

module scp_top #(
   parameter int N_ES = 4
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rstn,
   // serial input
   input  wire logic              i_bit_vld,
   input  wire logic              i_bit_dat,
   output logic                   o_bit_rdy,
   // control
   input  wire logic              i_ts_mode,
   input  wire logic              i_resync,
   input  wire logic [12:0]       i_pmt_pid,
   // routed payload
   output scp_pkg::scp_word_t     o_out,
   output logic                   o_out_vld,
   input  wire logic              i_out_rdy,
   // status
   output logic                   o_sc_found,
   output logic [7:0]             o_stream_id,
   output logic                   o_err,
   output logic                   o_aligned,
   output logic [12:0]            o_pcr_pid
);

   localparam int EW = $clog2(N_ES) + 1;

   // ******************************************************
   // parser state
   // ******************************************************
   scp_pkg::scp_state_t state_reg, state_next;
   logic [2:0]  bpos_reg, bpos_next;
   logic [6:0]  sr_reg, sr_next;
   logic        stuff_reg, stuff_next;
   logic [15:0] win_reg, win_next;
   logic        sidp_reg, sidp_next;
   logic [7:0]  pcnt_reg, pcnt_next;
   logic [7:0]  pidx_reg, pidx_next;
   logic [7:0]  afk_reg, afk_next;
   logic        pusi_reg, pusi_next;
   logic [12:0] pid_reg, pid_next;
   logic [1:0]  afc_reg, afc_next;
   logic [3:0]  fi_reg, fi_next;
   logic [11:0] rem_reg, rem_next;
   logic [11:0] sk_reg, sk_next;
   logic [2:0]  ep_reg, ep_next;
   logic [EW-1:0] ei_reg, ei_next;
   logic [4:0]  hi_reg, hi_next;
   logic [12:0] tpid_reg [N_ES];
   logic [12:0] tpid_next [N_ES];
   logic [N_ES-1:0] tvld_reg, tvld_next;
   logic [12:0] pcr_reg, pcr_next;
   logic        sc_reg, sc_next;
   logic [7:0]  sid_reg, sid_next;
   logic        err_reg, err_next;
   logic        alig_reg, alig_next;
   logic        push, hit;
   logic [1:0]  slot;
   logic [7:0]  b;
   scp_pkg::scp_word_t pword;

   // buffer state
   scp_pkg::scp_word_t mem_reg [2];
   scp_pkg::scp_word_t mem_next [2];
   logic [1:0]  cnt_reg, cnt_next;
   logic        vld_reg, vld_next;
   logic        rdy_reg, rdy_next;

   // ******************************************************
   // parser next state
   // ******************************************************
   always_comb begin
      state_next = state_reg;  bpos_next = bpos_reg;  sr_next = sr_reg;
      stuff_next = stuff_reg;  win_next = win_reg;    sidp_next = sidp_reg;
      pcnt_next = pcnt_reg;    pidx_next = pidx_reg;  afk_next = afk_reg;
      pusi_next = pusi_reg;    pid_next = pid_reg;    afc_next = afc_reg;
      fi_next = fi_reg;        rem_next = rem_reg;    sk_next = sk_reg;
      ep_next = ep_reg;        ei_next = ei_reg;      hi_next = hi_reg;
      tpid_next = tpid_reg;    tvld_next = tvld_reg;  pcr_next = pcr_reg;
      sid_next = sid_reg;      sc_next = 1'b0;        err_next = 1'b0;
      push = 1'b0;             pword = '0;
      b = {sr_reg, i_bit_dat};
      // identifier lookup in learned table
      hit = 1'b0;
      slot = 2'h0;
      for (int k = 0; k < N_ES; k++) begin
         if (tvld_reg[k] && tpid_reg[k] == pid_reg) begin
            hit = 1'b1;
            slot = k[1:0];
         end
      end
      if (i_resync) begin
         state_next = i_ts_mode ? scp_pkg::ST_TS_SYNC : scp_pkg::ST_SRCH;
         stuff_next = (bpos_reg != 3'h0);
         sidp_next = 1'b0;
         win_next = 16'hffff;
      end else if (i_bit_vld && rdy_reg) begin
         bpos_next = bpos_reg + 3'h1;
         sr_next = b[6:0];
         if (stuff_reg) begin
            // stuffing up to the boundary must be zero
            if (i_bit_dat) err_next = 1'b1;
            if (bpos_reg == 3'h7) stuff_next = 1'b0;
         end else if (bpos_reg == 3'h7) begin
            win_next = {win_reg[7:0], b};
            pidx_next = (pidx_reg == 8'hff) ? pidx_reg : pidx_reg + 8'h01;
            pcnt_next = pcnt_reg + 8'h01;
            unique case (state_reg)
               scp_pkg::ST_SRCH: begin
                  if (sidp_reg) begin
                     sc_next = 1'b1;
                     sid_next = b;
                     sidp_next = 1'b0;
                     pidx_next = 8'h00;
                     state_next = scp_pkg::ST_ES_PAY;
                  end else if ({win_reg, b} == `SCP_PREFIX) begin
                     sidp_next = 1'b1;
                  end else if (b != `SCP_PFX_ZERO) begin
                     err_next = 1'b1;
                  end
               end
               scp_pkg::ST_ES_PAY: begin
                  push = 1'b1;
                  pword = '{pid: 13'h0000, slot: 2'h0, first: (pidx_reg == 8'h00), data: b};
               end
               scp_pkg::ST_TS_SYNC: begin
                  if (b == `SCP_SYNC) begin
                     pcnt_next = `SCP_HDR_PIDH;
                     state_next = scp_pkg::ST_TS_HDR;
                  end
               end
               scp_pkg::ST_TS_HDR: begin
                  unique case (pcnt_reg)
                     `SCP_HDR_SYNC: if (b != `SCP_SYNC) begin
                        err_next = 1'b1;
                        state_next = scp_pkg::ST_TS_SYNC;
                     end
                     `SCP_HDR_PIDH: begin
                        pusi_next = b[`SCP_PUSI_BIT];
                        pid_next[12:8] = b[4:0];
                     end
                     `SCP_HDR_PIDL: pid_next[7:0] = b;
                     default: begin
                        afc_next = b[`SCP_AFC_HI:`SCP_AFC_LO];
                        pidx_next = 8'h00;
                        state_next = b[`SCP_AFC_HI] ? scp_pkg::ST_TS_AFL
                                                    : scp_pkg::ST_TS_PAY;
                     end
                  endcase
               end
               scp_pkg::ST_TS_AFL: begin
                  afk_next = b;
                  pidx_next = 8'h00;
                  if (b == 8'h00) state_next = scp_pkg::ST_TS_PAY;
                  else state_next = scp_pkg::ST_TS_AF;
               end
               scp_pkg::ST_TS_AF: begin
                  afk_next = afk_reg - 8'h01;
                  pidx_next = 8'h00;
                  if (afk_reg == 8'h01) state_next = scp_pkg::ST_TS_PAY;
               end
               scp_pkg::ST_TS_PAY: begin
                  if (afc_reg[0] && pid_reg != `SCP_NULL_PID) begin
                     if (pid_reg == i_pmt_pid) begin
                        if (pusi_reg && pidx_reg == 8'h00) begin
                           // pointer byte opens a new section
                           sk_next = {4'h0, b};
                           fi_next = 4'h0;
                           ei_next = '0;
                           ep_next = `SCP_EP_TYPE;
                           tvld_next = '0;
                        end else if (sk_reg != 12'h000) begin
                           sk_next = sk_reg - 12'h001;
                           if (fi_reg == `SCP_PM_LOOP) rem_next = rem_reg - 12'h001;
                        end else if (fi_reg != `SCP_PM_LOOP) begin
                           // fixed section fields, reserved bits dropped
                           unique case (fi_reg)
                              `SCP_PM_LENH: rem_next[11:8] = b[3:0];
                              `SCP_PM_LENL: rem_next[7:0] = b;
                              `SCP_PM_PCRH: hi_next = b[4:0];
                              `SCP_PM_PCRL: pcr_next = {hi_next, b};
                              `SCP_PM_PILH: sk_next[11:8] = b[3:0];
                              `SCP_PM_PILL: sk_next[7:0] = b;
                              default: ;
                           endcase
                           if (fi_reg >= `SCP_PM_CNT) rem_next = rem_next - 12'h001;
                           fi_next = fi_reg + 4'h1;
                        end else if (rem_reg > `SCP_PM_CRC) begin
                           // stream entry loop, index from zero
                           rem_next = rem_reg - 12'h001;
                           ep_next = ep_reg + 3'h1;
                           unique case (ep_reg)
                              `SCP_EP_PIDH: hi_next = b[4:0];
                              `SCP_EP_PIDL: if (ei_reg < EW'(N_ES)) begin
                                 tpid_next[ei_reg[EW-2:0]] = {hi_reg, b};
                                 tvld_next[ei_reg[EW-2:0]] = 1'b1;
                              end
                              `SCP_EP_EILH: sk_next[11:8] = b[3:0];
                              `SCP_EP_EILL: begin
                                 sk_next[7:0] = b;
                                 ep_next = `SCP_EP_TYPE;
                                 if (ei_reg < EW'(N_ES)) ei_next = ei_reg + EW'(1);
                              end
                              default: ;
                           endcase
                        end
                     end else if (hit) begin
                        push = 1'b1;
                        pword = '{pid: pid_reg, slot: slot,
                                  first: pusi_reg && pidx_reg == 8'h00, data: b};
                        if (pusi_reg && pidx_reg < `SCP_SID_IDX) begin
                           if (b != ((pidx_reg == `SCP_PFX_LAST) ? `SCP_PFX_ONE
                                                                 : `SCP_PFX_ZERO))
                              err_next = 1'b1;
                        end else if (pusi_reg && pidx_reg == `SCP_SID_IDX) begin
                           sc_next = 1'b1;
                           sid_next = b;
                        end
                     end
                  end
               end
               default: ;
            endcase
            // packet end: next byte is a header byte
            if (state_reg inside {scp_pkg::ST_TS_HDR, scp_pkg::ST_TS_AFL,
                                  scp_pkg::ST_TS_AF, scp_pkg::ST_TS_PAY}
                && pcnt_reg == `SCP_PKT_LAST && state_next != scp_pkg::ST_TS_SYNC) begin
               pcnt_next = `SCP_HDR_SYNC;
               state_next = scp_pkg::ST_TS_HDR;
            end
         end
      end
      alig_next = (bpos_next == 3'h0);
   end

   // parser registers
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= scp_pkg::ST_SRCH; bpos_reg <= 3'h0;  sr_reg <= 7'h00;
         stuff_reg <= 1'b0;   win_reg <= 16'hffff;  sidp_reg <= 1'b0;
         pcnt_reg <= 8'h00;   pidx_reg <= 8'h00;    afk_reg <= 8'h00;
         pusi_reg <= 1'b0;    pid_reg <= 13'h0000;  afc_reg <= 2'h0;
         fi_reg <= `SCP_PM_LOOP; rem_reg <= 12'h000; sk_reg <= 12'h000;
         ep_reg <= 3'h0;      ei_reg <= '0;         hi_reg <= 5'h00;
         tpid_reg <= '{default: 13'h0000};          tvld_reg <= '0;
         pcr_reg <= `SCP_NULL_PID; sc_reg <= 1'b0;  sid_reg <= 8'h00;
         err_reg <= 1'b0;     alig_reg <= 1'b1;
      end else begin
         state_reg <= state_next; bpos_reg <= bpos_next; sr_reg <= sr_next;
         stuff_reg <= stuff_next; win_reg <= win_next;   sidp_reg <= sidp_next;
         pcnt_reg <= pcnt_next;   pidx_reg <= pidx_next; afk_reg <= afk_next;
         pusi_reg <= pusi_next;   pid_reg <= pid_next;   afc_reg <= afc_next;
         fi_reg <= fi_next;       rem_reg <= rem_next;   sk_reg <= sk_next;
         ep_reg <= ep_next;       ei_reg <= ei_next;     hi_reg <= hi_next;
         tpid_reg <= tpid_next;   tvld_reg <= tvld_next;
         pcr_reg <= pcr_next;     sc_reg <= sc_next;     sid_reg <= sid_next;
         err_reg <= err_next;     alig_reg <= alig_next;
      end
   end

   // ******************************************************
   // two-entry output buffer
   // ******************************************************
   always_comb begin
      mem_next = mem_reg;
      cnt_next = cnt_reg;
      if (vld_reg && i_out_rdy) begin
         mem_next[0] = mem_reg[1];
         cnt_next = cnt_reg - 2'h1;
      end
      if (push) begin
         mem_next[cnt_next[0]] = pword;
         cnt_next = cnt_next + 2'h1;
      end
      vld_next = (cnt_next != 2'h0);
      rdy_next = (cnt_next != 2'h2);  // stall input while full
   end

   // buffer registers
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_reg <= '{default: '0};
         cnt_reg <= 2'h0;
         vld_reg <= 1'b0;
         rdy_reg <= 1'b1;
      end else begin
         mem_reg <= mem_next;
         cnt_reg <= cnt_next;
         vld_reg <= vld_next;
         rdy_reg <= rdy_next;
      end
   end

   // outputs straight from flops
   assign o_bit_rdy   = rdy_reg;
   assign o_out       = mem_reg[0];
   assign o_out_vld   = vld_reg;
   assign o_sc_found  = sc_reg;
   assign o_stream_id = sid_reg;
   assign o_err       = err_reg;
   assign o_aligned   = alig_reg;
   assign o_pcr_pid   = pcr_reg;

endmodule : scp_top

`default_nettype wire

// File: rtl/scp_defs.svh
// constants of the start code and transport packet parser
// assumes inclusion by scp_top.sv only, after the package
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// start code prefix and its bytes
`define SCP_PREFIX    24'h000001
`define SCP_PFX_ZERO  8'h00
`define SCP_PFX_ONE   8'h01
`define SCP_PFX_LAST  8'h02
`define SCP_SID_IDX   8'h03

// transport packet layout
`define SCP_SYNC      8'h47
`define SCP_NULL_PID  13'h1fff
`define SCP_PKT_LAST  8'hbb
`define SCP_HDR_SYNC  8'h00
`define SCP_HDR_PIDH  8'h01
`define SCP_HDR_PIDL  8'h02
`define SCP_HDR_CTRL  8'h03
`define SCP_PUSI_BIT  6
`define SCP_AFC_HI    5
`define SCP_AFC_LO    4

// program map section byte positions
`define SCP_PM_LENH   4'h1
`define SCP_PM_LENL   4'h2
`define SCP_PM_CNT    4'h3
`define SCP_PM_PCRH   4'h8
`define SCP_PM_PCRL   4'h9
`define SCP_PM_PILH   4'ha
`define SCP_PM_PILL   4'hb
`define SCP_PM_LOOP   4'hc
`define SCP_PM_CRC    12'h004

// program map stream entry byte positions
`define SCP_EP_TYPE   3'h0
`define SCP_EP_PIDH   3'h1
`define SCP_EP_PIDL   3'h2
`define SCP_EP_EILH   3'h3
`define SCP_EP_EILL   3'h4

`endif

// File: rtl/scp_pkg.sv
// types of the start code and transport packet parser
// assumes nothing beyond a SystemVerilog compiler
package scp_pkg;

   // parser states
   typedef enum logic [2:0] {
      ST_SRCH, ST_ES_PAY, ST_TS_SYNC, ST_TS_HDR, ST_TS_AFL, ST_TS_AF, ST_TS_PAY
   } scp_state_t;

   // one routed payload byte
   typedef struct packed {
      logic [12:0] pid;
      logic [1:0]  slot;
      logic        first;
      logic [7:0]  data;
   } scp_word_t;

endpackage : scp_pkg

// File: verification/scp_top_assertions.sv
// checker of the parser ports: pulses, alignment, buffer hold
// assumes the scp_top port list; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module scp_top_checker (
   // clock and reset
   input  wire logic               i_core_clk,
   input  wire logic               i_rstn,
   // watched ports
   input  wire logic               i_bit_vld,
   input  wire logic               o_bit_rdy,
   input  wire logic               i_resync,
   input  wire scp_pkg::scp_word_t o_out,
   input  wire logic               o_out_vld,
   input  wire logic               i_out_rdy,
   input  wire logic               o_sc_found,
   input  wire logic [7:0]         o_stream_id,
   input  wire logic               o_aligned,
   input  wire logic [12:0]        o_pcr_pid
);
   logic [2:0] pos_reg;
   logic [2:0] pos_next;

   // bit position of accepted bits, mod 8
   always_comb begin
      pos_next = pos_reg;
      if (i_bit_vld && o_bit_rdy && !i_resync) pos_next = pos_reg + 3'h1;
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) pos_reg <= 3'h0;
      else pos_reg <= pos_next;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   a_found_pulse: assert property (o_sc_found |=> !o_sc_found)
      else $error("start code flag longer than one cycle");
   a_found_aligned: assert property (o_sc_found |-> o_aligned)
      else $error("start code flagged off a byte boundary");
   a_align_count: assert property (o_aligned == (pos_reg == 3'h0))
      else $error("alignment flag disagrees with bit count");
   a_out_hold: assert property (o_out_vld && !i_out_rdy |=> o_out_vld && $stable(o_out))
      else $error("output word changed while stalled");
   a_rdy_full: assert property (!o_bit_rdy |-> o_out_vld)
      else $error("input refused with empty buffer");
   a_id_source: assert property ($changed(o_stream_id) |-> o_sc_found)
      else $error("stream id changed without start code");
   a_pcr_byte: assert property ($changed(o_pcr_pid) |-> o_aligned)
      else $error("clock reference id changed mid byte");
   a_push_byte: assert property ($rose(o_out_vld) |-> o_aligned)
      else $error("word pushed mid byte");
   a_null_drop: assert property (o_out_vld |-> o_out.pid != 13'h1fff)
      else $error("null packet payload delivered");
endmodule : scp_top_checker

bind scp_top scp_top_checker u_chk (.i_core_clk, .i_rstn, .i_bit_vld, .o_bit_rdy, .i_resync,
   .o_out, .o_out_vld, .i_out_rdy, .o_sc_found, .o_stream_id, .o_aligned, .o_pcr_pid);
`default_nettype wire

// File: verification/scp_stream_model.sv
// upstream bit source and downstream word sink around the parser
// assumes one clock; tasks are called from the bench just after a rising edge
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// stream partner
// ****************************************
module scp_stream_model (
   // clock and reset
   input  wire logic               i_core_clk,
   input  wire logic               i_rstn,
   // bit source
   output logic                    o_bit_vld,
   output logic                    o_bit_dat,
   input  wire logic               i_bit_rdy,
   // word sink
   input  wire scp_pkg::scp_word_t i_out,
   input  wire logic               i_out_vld,
   output logic                    o_out_rdy,
   input  wire logic               i_slow
);
   scp_pkg::scp_word_t got_q[$];
   logic [3:0]         pace_reg;

   initial begin
      o_bit_vld = 1'b0;
      o_bit_dat = 1'b0;
   end

   // top n bits of b, msb first, each held until taken
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         o_bit_vld <= 1'b1;
         o_bit_dat <= b[7-i];
         @(posedge i_core_clk);
         while (i_bit_rdy !== 1'b1) @(posedge i_core_clk);
      end
   endtask : send_bits

   // released line shows the inverse of the last bit
   task automatic idle();
      o_bit_vld <= 1'b0;
      o_bit_dat <= ~o_bit_dat;
   endtask : idle

   // whole bytes back to back, then release
   task automatic send_bytes(input logic [7:0] q[$]);
      foreach (q[k]) send_bits(q[k], 8);
      idle();
   endtask : send_bytes

   // ready every cycle, or one cycle in sixteen when slow
   // slower than one word per eight bits, so the buffer fills and stalls
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) pace_reg <= 4'h0;
      else pace_reg <= pace_reg + 4'h1;
   end
   assign o_out_rdy = !i_slow || (pace_reg == 4'h0);

   // collect every word taken
   always @(posedge i_core_clk) begin
      if (i_rstn && i_out_vld && o_out_rdy) got_q.push_back(i_out);
   end
endmodule : scp_stream_model
`default_nettype wire

// File: verification/start_code_and_ts_packet_parser_test.sv
// bench of the parser: reset, raw start codes, stuffing, transport routing
// assumes the stream model as source and sink and the bound checker
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module start_code_and_ts_packet_parser_test;
   logic               core_clk, rstn, bit_vld, bit_dat, bit_rdy, ts_mode, resync;
   logic               slow, out_rdy, out_vld, sc_found, err, aligned, rdy_low;
   logic [7:0]         stream_id;
   logic [12:0]        pmt_pid, pcr_pid;
   logic [7:0]         pkt[$];
   scp_pkg::scp_word_t out;
   int                 failures, checks_done, sc_cnt, err_cnt;

   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   scp_top u_dut (.i_core_clk(core_clk), .i_rstn(rstn), .i_bit_vld(bit_vld),
      .i_bit_dat(bit_dat), .o_bit_rdy(bit_rdy), .i_ts_mode(ts_mode), .i_resync(resync),
      .i_pmt_pid(pmt_pid), .o_out(out), .o_out_vld(out_vld), .i_out_rdy(out_rdy),
      .o_sc_found(sc_found), .o_stream_id(stream_id), .o_err(err), .o_aligned(aligned),
      .o_pcr_pid(pcr_pid));
   scp_stream_model u_model (.i_core_clk(core_clk), .i_rstn(rstn), .o_bit_vld(bit_vld),
      .o_bit_dat(bit_dat), .i_bit_rdy(bit_rdy), .i_out(out), .i_out_vld(out_vld),
      .o_out_rdy(out_rdy), .i_slow(slow));

   // event counters and refusal watch
   always @(posedge core_clk) begin
      if (sc_found === 1'b1) sc_cnt++;
      if (err === 1'b1) err_cnt++;
      if (bit_rdy === 1'b0) rdy_low = 1'b1;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic resync_to(input logic m);
      ts_mode <= m;
      resync  <= 1'b1;
      @(posedge core_clk);
      resync <= 1'b0;
      @(posedge core_clk);
   endtask : resync_to

   // pad with index bytes to a full packet and send
   task automatic ts_send();
      while (pkt.size() < 188) pkt.push_back(8'(pkt.size()));
      u_model.send_bytes(pkt);
   endtask : ts_send

   task automatic wait_words(input int n);
      for (int i = 0; i < 3000 && u_model.got_q.size() < n; i++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask : wait_words

   task automatic t_reset();
      check("reset outputs", {bit_rdy, out_vld, aligned, sc_found, err, stream_id, pcr_pid},
            {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 13'h1fff});
   endtask : t_reset

   task automatic t_raw();
      resync_to(1'b0);
      pkt = {8'h00, 8'h00, 8'h00, 8'h01, 8'he0, 8'hab, 8'hcd};
      u_model.send_bytes(pkt);
      wait_words(2);
      check("raw found", sc_cnt, 1);
      check("raw id", stream_id, 8'he0);
      check("raw count", u_model.got_q.size(), 2);
      check("raw word0", u_model.got_q[0], {13'h000, 2'h0, 1'b1, 8'hab});
      check("raw word1", u_model.got_q[1], {13'h000, 2'h0, 1'b0, 8'hcd});
      u_model.got_q.delete();
   endtask : t_raw

   task automatic t_stuff();
      u_model.send_bits(8'ha0, 3);
      u_model.idle();
      @(posedge core_clk);
      check("mid byte aligned", aligned, 1'b0);
      resync_to(1'b0);
      u_model.send_bits(8'h40, 5);
      pkt = {8'h5a, 8'h00, 8'h00, 8'h01, 8'hb5};
      u_model.send_bytes(pkt);
      wait_words(0);
      check("stuff errors", err_cnt, 2);
      check("stuff found", sc_cnt, 2);
      check("stuff id", stream_id, 8'hb5);
      check("stuff aligned", aligned, 1'b1);
      check("stuff words", u_model.got_q.size(), 0);
   endtask : t_stuff

   task automatic t_ts();
      pmt_pid <= 13'h100;
      resync_to(1'b1);
      pkt = {8'h12};
      u_model.send_bytes(pkt);
      pkt = {8'h47, 8'h41, 8'h00, 8'h10, 8'h00, 8'h02, 8'hb0, 8'h17, 8'h00, 8'h01, 8'hc1,
             8'h00, 8'h00, 8'he1, 8'h01, 8'hf0, 8'h00, 8'h1b, 8'he1, 8'h01, 8'hf0, 8'h00,
             8'h04, 8'he1, 8'h02, 8'hf0, 8'h00};
      ts_send();
      wait_words(0);
      check("clock ref id", pcr_pid, 13'h101);
      slow <= 1'b1;
      // clear payloads only, so no access table is needed
      pkt = {8'h47, 8'h41, 8'h02, 8'h10, 8'h00, 8'h00, 8'h01, 8'hc0};
      ts_send();
      wait_words(184);
      check("es found", sc_cnt, 3);
      check("es id", stream_id, 8'hc0);
      check("stall refused", rdy_low, 1'b1);
      check("es count", u_model.got_q.size(), 184);
      check("es word0", u_model.got_q[0], {13'h102, 2'h1, 1'b1, 8'h00});
      check("es word183", u_model.got_q[183], {13'h102, 2'h1, 1'b0, 8'hbb});
      u_model.got_q.delete();
      slow <= 1'b0;
      pkt = {8'h47, 8'h1f, 8'hff, 8'h10};
      ts_send();
      // adaptation only: nothing of this packet may reach the sink
      pkt = {8'h47, 8'h01, 8'h01, 8'h20, 8'hb7};
      ts_send();
      pkt = {8'h47, 8'h01, 8'h01, 8'h30, 8'h02, 8'hff, 8'hff, 8'h00, 8'h00, 8'h01, 8'he0};
      ts_send();
      wait_words(181);
      check("af count", u_model.got_q.size(), 181);
      check("af word0", u_model.got_q[0], {13'h101, 2'h0, 1'b0, 8'h00});
      check("af no header", sc_cnt, 3);
      pkt = {8'h48};
      ts_send();
      wait_words(0);
      check("sync loss", err_cnt, 3);
   endtask : t_ts

   initial begin
      rstn = 1'b0;
      ts_mode = 1'b0;
      resync = 1'b0;
      slow = 1'b0;
      pmt_pid = 13'h000;
      rdy_low = 1'b0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_raw();
      t_stuff();
      t_ts();
      finish_test();
   end

   // hang guard, well beyond the expected run
   initial begin
      repeat (40000) @(posedge core_clk);
      failures++;
      finish_test();
   end
endmodule : start_code_and_ts_packet_parser_test
`default_nettype wire
